// File: pkg/ts_regs_cfg.svh
`ifndef TS_REGS_CFG_SVH
`define TS_REGS_CFG_SVH
`define OFS_IRQ_STATUS 8'h00
`define OFS_IRQ_STATUS_CLEAR 8'h04
`define OFS_IRQ_ENABLE 8'h08
`define OFS_DEBUG_SUSPEND_CONTROL 8'h0C
`define OFS_TX_PACKET_GAP 8'h10
`define OFS_ASSOC_TABLE_SENSE_CFG 8'h14
`define OFS_STREAM_MODE 8'h18
`define BIT_BOUNDARY 0
`define BIT_PAT_DETECT 2
`define BIT_FREE_RUN 0
`define BIT_SOFT_STOP 1
`define BIT_SENSE_EN 16
`define BIT_MODE_ASYNC 0
`define BIT_MODE_PARALLEL 1
`define SERIAL_CLK_PER_BYTE 11'h008
`define PARALLEL_CLK_PER_BYTE 11'h001
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// File: pkg/ts_regs_pkg.sv
package ts_regs_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_GAP, ST_HALT} tx_state_t;
  typedef struct packed {
    logic [7:0] seq;
    logic cni;
    logic pusi;
    logic [4:0] version;
    logic [15:0] program_number;
  } pat_info_t;
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] status;
    logic [2:0] irq_en;
    logic free_run;
    logic [7:0] gap_bytes;
    logic sense_en;
    logic [15:0] prog_num;
    logic [4:0] last_version;
    logic version_valid;
    logic async_mode;
    logic parallel_mode;
    tx_state_t state;
    logic [10:0] gap_cnt;
  } regs_state_t;
endpackage : ts_regs_pkg

// File: src/ts_emu_txwait_pat_sense_regs.sv
`timescale 1ns/10ps
`include "ts_regs_cfg.svh"
// Operation
// - status clear bit 0 drops boundary flag
// - soft stop bit reads one, ignores writes
// - free run ignores suspend input
// - free run zero obeys soft stop
// - eight bit gap byte count
// - gap only in asynchronous transmit
// - serial gap is bytes times eight
// - parallel gap is bytes times one
// - sense enable bit sixteen gates filter
// - new PAT version sets status bit two
// - program number readable for debug
module ts_emu_txwait_pat_sense_regs import ts_regs_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // axi4-lite write address and data
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // stream side events and status
  input wire logic BOUNDARY_EVENT,
  input wire logic PAT_VALID,
  input wire pat_info_t PAT_INFO,
  input wire logic PKT_END,
  input wire logic EMU_SUSPEND,
  output logic TX_HOLD,
  output logic HALTED,
  output logic IRQ,
  output logic PAT_IRQ_PULSE
);

  // unmapped offsets answer slverr and change nothing
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_STATUS_CLEAR) || (a == `OFS_IRQ_ENABLE) ||
                 (a == `OFS_DEBUG_SUSPEND_CONTROL) || (a == `OFS_TX_PACKET_GAP) ||
                 (a == `OFS_ASSOC_TABLE_SENSE_CFG) || (a == `OFS_STREAM_MODE);
  endfunction : known_addr

  regs_state_t st_ff;
  regs_state_t nxt_st;
  logic wr_fire;
  logic rd_fire;
  logic pat_hit;
  logic [2:0] clr_bits;
  logic [2:0] set_bits;
  logic suspend_req;
  logic [31:0] rd_val;
  logic [10:0] gap_len;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  assign AWREADY = !st_ff.aw_got && !st_ff.bvalid;
  assign WREADY = !st_ff.w_got && !st_ff.bvalid;
  assign ARREADY = !st_ff.rvalid;
  assign BVALID = st_ff.bvalid;
  assign BRESP = st_ff.bresp;
  assign RVALID = st_ff.rvalid;
  assign RDATA = st_ff.rdata;
  assign RRESP = st_ff.rresp;
  assign wr_fire = (st_ff.aw_got || (AWVALID && AWREADY)) && (st_ff.w_got || (WVALID && WREADY));
  assign rd_fire = ARVALID && ARREADY;
  // a half taken earlier is replayed from the holding flops
  assign wr_addr = st_ff.aw_got ? st_ff.aw_addr : AWADDR;
  assign wr_data = st_ff.w_got ? st_ff.w_data : WDATA;

  // ----------------------------------------
  // events and derived controls
  // ----------------------------------------
  // version compare needs one prior table; the first seen counts as changed
  assign pat_hit = st_ff.sense_en && PAT_VALID && PAT_INFO.cni && PAT_INFO.pusi &&
                   (!st_ff.version_valid || PAT_INFO.version != st_ff.last_version);
  assign set_bits = {pat_hit, 1'b0, BOUNDARY_EVENT};
  assign suspend_req = EMU_SUSPEND && !st_ff.free_run;
  // parallel moves a byte per clock, serial a bit per clock
  assign gap_len = st_ff.parallel_mode ? {3'h0, st_ff.gap_bytes} * `PARALLEL_CLK_PER_BYTE
                                       : {3'h0, st_ff.gap_bytes} * `SERIAL_CLK_PER_BYTE;
  assign TX_HOLD = st_ff.state != ST_RUN;
  assign HALTED = st_ff.state == ST_HALT;
  // level output; software clears status or its enable bit to drop it
  assign IRQ = |(st_ff.status & st_ff.irq_en);
  assign PAT_IRQ_PULSE = pat_hit;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (ARADDR)
      `OFS_IRQ_STATUS: rd_val = {29'h0, st_ff.status};
      `OFS_IRQ_ENABLE: rd_val = {29'h0, st_ff.irq_en};
      `OFS_DEBUG_SUSPEND_CONTROL: rd_val = {30'h0, 1'b1, st_ff.free_run};
      `OFS_TX_PACKET_GAP: rd_val = {24'h0, st_ff.gap_bytes};
      `OFS_ASSOC_TABLE_SENSE_CFG: rd_val = {15'h0, st_ff.sense_en, st_ff.prog_num};
      `OFS_STREAM_MODE: rd_val = {30'h0, st_ff.parallel_mode, st_ff.async_mode};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    clr_bits = 3'h0;
    if (AWVALID && AWREADY) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = WDATA;
    end
    if (wr_fire) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = known_addr(wr_addr) ? `AXI_OKAY : `AXI_SLVERR;
      case (wr_addr)
        `OFS_IRQ_STATUS_CLEAR: if (WSTRB[0] || st_ff.w_got) clr_bits = wr_data[2:0];
        `OFS_IRQ_ENABLE: nxt_st.irq_en = wr_data[2:0];
        `OFS_DEBUG_SUSPEND_CONTROL: nxt_st.free_run = wr_data[`BIT_FREE_RUN];
        `OFS_TX_PACKET_GAP: nxt_st.gap_bytes = wr_data[7:0];
        `OFS_ASSOC_TABLE_SENSE_CFG: nxt_st.sense_en = wr_data[`BIT_SENSE_EN];
        `OFS_STREAM_MODE: begin
          nxt_st.async_mode = wr_data[`BIT_MODE_ASYNC];
          nxt_st.parallel_mode = wr_data[`BIT_MODE_PARALLEL];
        end
        default: nxt_st.bresp = known_addr(wr_addr) ? `AXI_OKAY : `AXI_SLVERR;
      endcase
    end
    if (st_ff.bvalid && BREADY) nxt_st.bvalid = 1'b0;
    // read data registered so it stands until rready
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_val;
      nxt_st.rresp = known_addr(ARADDR) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (st_ff.rvalid && RREADY) begin
      nxt_st.rvalid = 1'b0;
    end
    // set wins over a clear in the same cycle
    nxt_st.status = (st_ff.status & ~clr_bits) | set_bits;
    if (pat_hit) begin
      nxt_st.last_version = PAT_INFO.version;
      nxt_st.version_valid = 1'b1;
      nxt_st.prog_num = PAT_INFO.program_number;
    end
    // gap counter is 11 bits: 255 bytes times 8 fits
    case (st_ff.state)
      ST_RUN: begin
        // stop only at a packet edge, never mid packet
        if (PKT_END && suspend_req) nxt_st.state = ST_HALT;
        else if (PKT_END && st_ff.async_mode && gap_len != 11'h000) begin
          nxt_st.state = ST_GAP;
          nxt_st.gap_cnt = gap_len - 11'h001;
        end
      end
      ST_GAP: begin
        if (st_ff.gap_cnt == 11'h000) nxt_st.state = suspend_req ? ST_HALT : ST_RUN;
        else nxt_st.gap_cnt = st_ff.gap_cnt - 11'h001;
      end
      ST_HALT: if (!suspend_req) nxt_st.state = ST_RUN;
      default: nxt_st.state = ST_RUN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_clear_boundary;
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_fire && clr_bits[`BIT_BOUNDARY] && !BOUNDARY_EVENT) |=> !st_ff.status[`BIT_BOUNDARY];
  endproperty
  a_clear_boundary: assert property (p_clear_boundary) else $error("boundary flag not cleared");

  property p_soft_reads_one;
    @(posedge CLOCK) disable iff (!RST_N)
    (rd_fire && ARADDR == `OFS_DEBUG_SUSPEND_CONTROL) |=> st_ff.rdata[`BIT_SOFT_STOP] && st_ff.rdata[31:2] == 30'h0;
  endproperty
  a_soft_reads_one: assert property (p_soft_reads_one) else $error("soft stop bit not one");

  property p_halt_at_end;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_ff.state == ST_RUN && !PKT_END) |=> st_ff.state != ST_HALT;
  endproperty
  a_halt_at_end: assert property (p_halt_at_end) else $error("halt mid packet");

  property p_free_run;
    @(posedge CLOCK) disable iff (!RST_N)
    st_ff.free_run && st_ff.state == ST_HALT |=> st_ff.state == ST_RUN;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run still halted");

  property p_suspend;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_ff.state == ST_RUN && PKT_END && EMU_SUSPEND && !st_ff.free_run) |=> HALTED;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend not honoured");

  property p_sync_no_gap;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_ff.state == ST_RUN && !st_ff.async_mode && !suspend_req) |=> st_ff.state == ST_RUN;
  endproperty
  a_sync_no_gap: assert property (p_sync_no_gap) else $error("gap outside async mode");

  property p_serial_gap;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_ff.state == ST_RUN && nxt_st.state == ST_GAP && !st_ff.parallel_mode)
      |=> st_ff.gap_cnt == {st_ff.gap_bytes, 3'h0} - 11'h001;
  endproperty
  a_serial_gap: assert property (p_serial_gap) else $error("serial gap length wrong");

  property p_parallel_gap;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_ff.state == ST_RUN && nxt_st.state == ST_GAP && st_ff.parallel_mode)
      |=> st_ff.gap_cnt == {3'h0, st_ff.gap_bytes} - 11'h001;
  endproperty
  a_parallel_gap: assert property (p_parallel_gap) else $error("parallel gap length wrong");

  property p_pat_status;
    @(posedge CLOCK) disable iff (!RST_N)
    PAT_IRQ_PULSE |=> st_ff.status[`BIT_PAT_DETECT] && st_ff.last_version == $past(PAT_INFO.version);
  endproperty
  a_pat_status: assert property (p_pat_status) else $error("pat status not set");

  property p_sticky;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_ff.status[`BIT_PAT_DETECT] && !(wr_fire && clr_bits[`BIT_PAT_DETECT])) |=> st_ff.status[`BIT_PAT_DETECT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("pat status lost");

  property p_clear_zero;
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_fire && wr_addr == `OFS_IRQ_STATUS_CLEAR && !wr_data[`BIT_BOUNDARY] && st_ff.status[`BIT_BOUNDARY])
      |=> st_ff.status[`BIT_BOUNDARY];
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("boundary flag cleared by zero");

  property p_gap_field;
    @(posedge CLOCK) disable iff (!RST_N)
    (rd_fire && ARADDR == `OFS_TX_PACKET_GAP) |=> st_ff.rdata == {24'h000000, $past(st_ff.gap_bytes)};
  endproperty
  a_gap_field: assert property (p_gap_field) else $error("gap field readback wrong");

  property p_gap_refused;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_ff.state == ST_RUN && PKT_END && !suspend_req && st_ff.gap_bytes == 8'h00) |=> st_ff.state == ST_RUN;
  endproperty
  a_gap_refused: assert property (p_gap_refused) else $error("gap inserted with zero count");

  property p_sense_off;
    @(posedge CLOCK) disable iff (!RST_N)
    (PAT_VALID && !st_ff.sense_en) |-> !PAT_IRQ_PULSE ##1 $stable(st_ff.prog_num);
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("pat sensed while disabled");

  property p_prog_num;
    @(posedge CLOCK) disable iff (!RST_N)
    PAT_IRQ_PULSE |=> st_ff.prog_num == $past(PAT_INFO.program_number);
  endproperty
  a_prog_num: assert property (p_prog_num) else $error("program number not captured");

  property p_reserved_zero;
    @(posedge CLOCK) disable iff (!RST_N)
    (rd_fire && ARADDR == `OFS_ASSOC_TABLE_SENSE_CFG) |=> st_ff.rdata[31:17] == 15'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  c_halt: cover property (@(posedge CLOCK) disable iff (!RST_N) HALTED);
  c_gap: cover property (@(posedge CLOCK) disable iff (!RST_N) st_ff.state == ST_GAP);
  c_pat: cover property (@(posedge CLOCK) disable iff (!RST_N) PAT_IRQ_PULSE);
  c_irq: cover property (@(posedge CLOCK) disable iff (!RST_N) IRQ);
  c_gap_halt: cover property (@(posedge CLOCK) disable iff (!RST_N) st_ff.state == ST_GAP && suspend_req);

endmodule : ts_emu_txwait_pat_sense_regs

// File: test/stream_host_model.sv
`timescale 1ns/10ps
// ----------
// far side pacing probe
// ----------
module stream_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench request and device pacing
  input wire logic send,
  input wire logic tx_hold,
  output logic pkt_end,
  output logic [11:0] hold_len
);
  logic pkt_end_ff;
  logic [11:0] hold_len_ff;
  // gap is measured here, never taken from the device
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_end_ff <= 1'b0;
      hold_len_ff <= 12'h000;
    end else begin
      pkt_end_ff <= send;
      if (pkt_end_ff) hold_len_ff <= 12'h000;
      else if (tx_hold) hold_len_ff <= hold_len_ff + 12'h001;
    end
  end
  assign pkt_end = pkt_end_ff;
  assign hold_len = hold_len_ff;
endmodule : stream_host_model

// File: test/ts_emu_txwait_pat_sense_regs_test.sv
`timescale 1ns/10ps
module ts_emu_txwait_pat_sense_regs_test import ts_regs_pkg::*;;
  logic CLOCK = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_HOLD, HALTED, IRQ, PAT_IRQ_PULSE, PKT_END, pl;
  logic BOUNDARY_EVENT = 0, PAT_VALID = 0, EMU_SUSPEND = 0, send = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA, rd;
  logic [3:0] WSTRB = 4'hF;
  logic [1:0] BRESP, RRESP, rsp;
  logic [11:0] hold_len;
  logic [1:0] md [5] = '{2'h1, 2'h3, 2'h3, 2'h1, 2'h2};
  logic [7:0] gp [5] = '{8'h02, 8'h05, 8'hFF, 8'h00, 8'h09};
  logic [31:0] ex [5] = '{32'h10, 32'h5, 32'hFF, 32'h0, 32'h0};
  pat_info_t PAT_INFO = '0;
  int failures = 0, total_checks = 0, cyc = 0;
  always #20 CLOCK = ~CLOCK;
  ts_emu_txwait_pat_sense_regs uut (.CLOCK(CLOCK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .BOUNDARY_EVENT(BOUNDARY_EVENT),
    .PAT_VALID(PAT_VALID), .PAT_INFO(PAT_INFO), .PKT_END(PKT_END), .EMU_SUSPEND(EMU_SUSPEND),
    .TX_HOLD(TX_HOLD), .HALTED(HALTED), .IRQ(IRQ), .PAT_IRQ_PULSE(PAT_IRQ_PULSE));
  stream_host_model host (.clk(CLOCK), .rst_n(RST_N), .send(send), .tx_hold(TX_HOLD),
    .pkt_end(PKT_END), .hold_len(hold_len));
  // ----------
  // shared tasks
  // ----------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rd = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
    chk(n, rd, e);
  endtask : rc
  task automatic pkt(input int w);
    @(posedge CLOCK) send <= 1'b1;
    @(posedge CLOCK) send <= 1'b0;
    repeat (w) @(posedge CLOCK);
  endtask : pkt
  task automatic pat(input logic [4:0] v);
    @(posedge CLOCK);
    PAT_INFO <= '{8'h00, 1'b1, 1'b1, v, 16'h1234};
    PAT_VALID <= 1'b1;
    #1 pl = PAT_IRQ_PULSE;
    @(posedge CLOCK) PAT_VALID <= 1'b0;
  endtask : pat
  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // a hang counts as a failure
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      conclude();
    end
  end
  // ----------
  // tests
  // ----------
  initial begin
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    rc(8'h0C, 32'h2, "suspend ctl");
    wr(8'h0C, 32'hFFFFFFFF);
    rc(8'h0C, 32'h3, "suspend ctl");
    wr(8'h10, 32'hFFFFFFFF);
    rc(8'h10, 32'hFF, "gap reg");
    wr(8'h1C, 32'hFFFFFFFF);
    chk("unmapped wr", {30'h0, rsp}, 32'h2);
    rc(8'h1C, 32'h0, "unmapped rd");
    chk("unmapped rd", {30'h0, rsp}, 32'h2);
    for (int i = 0; i < 5; i++) begin
      wr(8'h18, {30'h0, md[i]});
      wr(8'h10, {24'h0, gp[i]});
      pkt(ex[i] + 6);
      chk("gap len", {20'h0, hold_len}, ex[i]);
    end
    // sync mode left selected so suspend runs without gaps
    wr(8'h0C, 32'h0);
    rc(8'h0C, 32'h2, "suspend ctl");
    @(posedge CLOCK) EMU_SUSPEND <= 1'b1;
    repeat (3) @(posedge CLOCK);
    chk("halt mid pkt", {31'h0, HALTED}, 32'h0);
    pkt(2);
    chk("halt at end", {31'h0, HALTED}, 32'h1);
    wr(8'h0C, 32'h1);
    pkt(2);
    chk("free run", {31'h0, HALTED}, 32'h0);
    @(posedge CLOCK) EMU_SUSPEND <= 1'b0;
    wr(8'h08, 32'h5);
    @(posedge CLOCK) BOUNDARY_EVENT <= 1'b1;
    @(posedge CLOCK) BOUNDARY_EVENT <= 1'b0;
    wr(8'h04, 32'h0);
    rc(8'h00, 32'h1, "status");
    chk("irq", {31'h0, IRQ}, 32'h1);
    wr(8'h04, 32'h1);
    rc(8'h00, 32'h0, "status");
    chk("irq", {31'h0, IRQ}, 32'h0);
    pat(5'h03);
    chk("pat off", {31'h0, pl}, 32'h0);
    rc(8'h00, 32'h0, "status");
    wr(8'h14, 32'hFFFFFFFF);
    rc(8'h14, 32'h10000, "sense cfg");
    pat(5'h03);
    chk("pat pulse", {31'h0, pl}, 32'h1);
    rc(8'h00, 32'h4, "status");
    chk("irq pat", {31'h0, IRQ}, 32'h1);
    rc(8'h14, 32'h11234, "sense cfg");
    wr(8'h08, 32'h0);
    chk("irq masked", {31'h0, IRQ}, 32'h0);
    rc(8'h00, 32'h4, "status");
    wr(8'h04, 32'h4);
    rc(8'h00, 32'h0, "status");
    pat(5'h03);
    chk("same ver", {31'h0, pl}, 32'h0);
    conclude();
  end
endmodule : ts_emu_txwait_pat_sense_regs_test
